// *** nps_host.sv ***
// Host controller: power-up reset, protection-status read, write-protect abort
`timescale 1ns/1ps
`include "nps_defs.svh"
module nps_host #(
  parameter int PWR_WAIT_CYC  = `NPS_PWR_CYC,
  parameter int INIT_WAIT_CYC = `NPS_INIT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_ce_n,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_we_n,
  output logic             o_re_n,
  output logic             o_wp_n,
  input  wire logic [7:0]  i_io,
  output logic      [7:0]  o_io,
  output logic             o_io_oe,
  input  wire logic        i_rb_n
);
  localparam int WP_SET_C  = `NPS_WW_CYC;
  localparam int WP_SET_M1 = `NPS_WW_CYC - 1;

  generate
    if (PWR_WAIT_CYC < 1 || PWR_WAIT_CYC > 1048575 ||
        INIT_WAIT_CYC < 1 || INIT_WAIT_CYC > 1048575 || WP_SET_C > 31)
    begin : g_chk
      $error("nps_host: wait counts out of range for timer");
    end
  endgenerate

  nps_cyc_if cyc ();

  nps_cycle u_cycle (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .cyc     (cyc.eng),
    .i_io    (i_io),
    .o_io    (o_io),
    .o_io_oe (o_io_oe),
    .o_cle   (o_cle),
    .o_ale   (o_ale),
    .o_we_n  (o_we_n),
    .o_re_n  (o_re_n)
  );

  nps_pkg::nps_state_t st_r;
  nps_pkg::nps_state_t st_nxt;
  nps_pkg::nps_op_t    op_r;
  nps_pkg::nps_lock_t  prot_r;
  logic [2:0]          step_r;
  logic [19:0]         tmr_r;
  logic [19:0]         tmr_nxt;
  logic                step_inc;
  logic [10:0]         ba_r;
  logic [7:0]          raw_r;
  logic [7:0]          dstat_r;
  logic                wp_ctl_r;
  logic                wp_r;
  logic [4:0]          ww_cnt_r;
  logic                pwr_ok_r;
  logic                init_done_r;
  logic                refused_r;
  logic                timeout_r;
  logic                read_setup_r;
  logic                invalid_r;
  logic                rb_m_r;
  logic                rb_s_r;
  logic                ce_n_r;
  logic [31:0]         rdata_r;

  function automatic nps_pkg::nps_act_t step_act(nps_pkg::nps_op_t op, logic [2:0] s);
    step_act = nps_pkg::NPS_A_END;
    unique case (op)
      // 7Ah, three address bytes, wait, one data byte
      nps_pkg::NPS_OP_PROT:
        unique case (s)
          3'h0: step_act = nps_pkg::NPS_A_CMD;
          3'h1, 3'h2, 3'h3: step_act = nps_pkg::NPS_A_ADDR;
          3'h4: step_act = nps_pkg::NPS_A_WHR;
          3'h5: step_act = nps_pkg::NPS_A_DOUT;
          default: step_act = nps_pkg::NPS_A_END;
        endcase
      nps_pkg::NPS_OP_STAT:
        unique case (s)
          3'h0: step_act = nps_pkg::NPS_A_CMD;
          3'h1: step_act = nps_pkg::NPS_A_WHR;
          3'h2: step_act = nps_pkg::NPS_A_DOUT;
          default: step_act = nps_pkg::NPS_A_END;
        endcase
      // abort is followed by the reset busy period
      nps_pkg::NPS_OP_ABORT:
        unique case (s)
          3'h0: step_act = nps_pkg::NPS_A_HOLD;
          3'h1: step_act = nps_pkg::NPS_A_WB;
          3'h2: step_act = nps_pkg::NPS_A_BUSY;
          default: step_act = nps_pkg::NPS_A_END;
        endcase
      default:
        unique case (s)
          3'h0: step_act = nps_pkg::NPS_A_CMD;
          3'h1: step_act = nps_pkg::NPS_A_WB;
          3'h2: step_act = nps_pkg::NPS_A_BUSY;
          default: step_act = nps_pkg::NPS_A_END;
        endcase
    endcase
  endfunction

  wire nps_pkg::nps_act_t act_w = step_act(op_r, step_r);
  wire [7:0] cmd_w = (op_r == nps_pkg::NPS_OP_INIT) ? `NPS_CMD_RESET :
                     (op_r == nps_pkg::NPS_OP_PROT) ? `NPS_CMD_PROT_RD :
                     (op_r == nps_pkg::NPS_OP_STAT) ? `NPS_CMD_STAT_RD : raw_r;
  // block address spread over three address bytes
  wire [7:0] addr_w = (step_r == 3'h1) ? {ba_r[1:0], 6'h00} :
                      (step_r == 3'h2) ? ba_r[9:2] : {7'h00, ba_r[10]};
  wire is_pin_w = act_w == nps_pkg::NPS_A_CMD || act_w == nps_pkg::NPS_A_ADDR ||
                  act_w == nps_pkg::NPS_A_DOUT;
  wire setup_w = act_w == nps_pkg::NPS_A_CMD &&
                 (cmd_w == `NPS_CMD_PROG_SU || cmd_w == `NPS_CMD_ERASE_SU);
  wire ww_ok = ww_cnt_r == 5'(WP_SET_C);
  wire st_step = st_r == nps_pkg::NPS_S_STEP;
  wire st_busy = st_r == nps_pkg::NPS_S_BUSY;
  wire st_hold = st_r == nps_pkg::NPS_S_HOLD;
  wire tmr_zero = tmr_r == 20'h00000;

  // setup command waits for a settled write-protect
  assign cyc.req  = st_step && is_pin_w && !(setup_w && !ww_ok);
  assign cyc.kind = act_w == nps_pkg::NPS_A_CMD  ? nps_pkg::NPS_K_CMD :
                    act_w == nps_pkg::NPS_A_ADDR ? nps_pkg::NPS_K_ADDR : nps_pkg::NPS_K_DOUT;
  assign cyc.data = act_w == nps_pkg::NPS_A_ADDR ? addr_w : cmd_w;

  // Software port decode
  wire nps_pkg::nps_op_t op_in = nps_pkg::nps_op_t'(i_wdata[2:0]);
  wire wr_cmd = i_ce && i_wr && i_addr == `NPS_REG_CMD;
  // nothing but reset or status read before init
  // after init any code up to 4 (abort) is let through
  wire legal = i_wdata[2:0] <= 3'h4 &&
               (init_done_r || op_in == nps_pkg::NPS_OP_INIT || op_in == nps_pkg::NPS_OP_STAT);
  // abort may cut into a program/erase busy wait
  wire start = wr_cmd && legal && (st_r == nps_pkg::NPS_S_IDLE ||
               (st_busy && op_in == nps_pkg::NPS_OP_ABORT));
  wire op_end = st_step && act_w == nps_pkg::NPS_A_END;
  wire wp_nxt = wp_ctl_r && init_done_r && !st_hold;
  wire locked_w = !prot_r.perm_unprot || !prot_r.vol_unprot;
  wire [31:0] stat_w = {24'h000000, locked_w, invalid_r, read_setup_r, timeout_r,
                        refused_r, init_done_r, rb_s_r, !ce_n_r};
  wire [31:0] rd_mux = (i_addr == `NPS_REG_CTRL)  ? {31'h00000000, wp_ctl_r} :
                       (i_addr == `NPS_REG_CMD)   ? {16'h0000, raw_r, 5'h00, op_r} :
                       (i_addr == `NPS_REG_BADDR) ? {21'h000000, ba_r} :
                       (i_addr == `NPS_REG_STAT)  ? stat_w :
                       (i_addr == `NPS_REG_PROT)  ? {24'h000000, prot_r} :
                       (i_addr == `NPS_REG_DSTAT) ? {24'h000000, dstat_r} : 32'h00000000;

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_zero ? tmr_r : tmr_r - 20'h00001;
    step_inc = 1'b0;
    unique case (st_r)
      nps_pkg::NPS_S_IDLE:
        if (start && op_in == nps_pkg::NPS_OP_INIT && !pwr_ok_r)
        begin
          st_nxt = nps_pkg::NPS_S_PWR;
          tmr_nxt = 20'(PWR_WAIT_CYC - 1);
        end
        else if (start)
          st_nxt = nps_pkg::NPS_S_STEP;
      nps_pkg::NPS_S_PWR, nps_pkg::NPS_S_WAIT, nps_pkg::NPS_S_HOLD:
        if (tmr_zero)
          st_nxt = nps_pkg::NPS_S_STEP;
      nps_pkg::NPS_S_BUSY:
        if (start)
          st_nxt = nps_pkg::NPS_S_STEP;
        else if (rb_s_r || tmr_zero)
          st_nxt = nps_pkg::NPS_S_STEP;
      nps_pkg::NPS_S_STEP:
        unique case (act_w)
          nps_pkg::NPS_A_CMD, nps_pkg::NPS_A_ADDR, nps_pkg::NPS_A_DOUT:
            step_inc = cyc.done;
          nps_pkg::NPS_A_WHR:
          begin
            st_nxt = nps_pkg::NPS_S_WAIT;
            tmr_nxt = 20'(`NPS_WHR_CYC - 1);
            step_inc = 1'b1;
          end
          nps_pkg::NPS_A_WB:
          begin
            st_nxt = nps_pkg::NPS_S_WAIT;
            tmr_nxt = 20'(`NPS_WB_CYC - 1);
            step_inc = 1'b1;
          end
          nps_pkg::NPS_A_BUSY:
          begin
            st_nxt = nps_pkg::NPS_S_BUSY;
            tmr_nxt = 20'(INIT_WAIT_CYC - 1);
            step_inc = 1'b1;
          end
          // write-protect low for the full write protect time
          nps_pkg::NPS_A_HOLD:
          begin
            st_nxt = nps_pkg::NPS_S_HOLD;
            tmr_nxt = 20'(WP_SET_M1);
            step_inc = 1'b1;
          end
          nps_pkg::NPS_A_END:
            st_nxt = nps_pkg::NPS_S_IDLE;
        endcase
    endcase
  end

  // busy line is an open-drain wire, synced
  always_ff @(posedge i_clk)
    if (i_srst)
    begin
      rb_m_r <= 1'b0;
      rb_s_r <= 1'b0;
    end
    else if (i_ce)
    begin
      rb_m_r <= i_rb_n;
      rb_s_r <= rb_m_r;
    end

  always_ff @(posedge i_clk)
    if (i_srst)
    begin
      st_r <= nps_pkg::NPS_S_IDLE;
      tmr_r <= 20'h00000;
      step_r <= 3'h0;
      op_r <= nps_pkg::NPS_OP_INIT;
      raw_r <= 8'h00;
      ce_n_r <= 1'b1;
    end
    else if (i_ce)
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      step_r <= start ? 3'h0 : step_r + {2'h0, step_inc};
      op_r <= start ? op_in : op_r;
      raw_r <= start ? i_wdata[15:8] : raw_r;
      ce_n_r <= start ? 1'b0 : (op_end ? 1'b1 : ce_n_r);
    end

  always_ff @(posedge i_clk)
    if (i_srst)
    begin
      wp_ctl_r <= 1'b0;
      ba_r <= 11'h000;
      wp_r <= 1'b0;
      ww_cnt_r <= 5'h00;
    end
    else if (i_ce)
    begin
      wp_ctl_r <= (i_wr && i_addr == `NPS_REG_CTRL) ? i_wdata[0] : wp_ctl_r;
      ba_r <= (i_wr && i_addr == `NPS_REG_BADDR) ? i_wdata[10:0] : ba_r;
      wp_r <= wp_nxt;
      ww_cnt_r <= (wp_nxt != wp_r) ? 5'h00 : (ww_ok ? ww_cnt_r : ww_cnt_r + 5'h01);
    end

  // Flags: a start clears refused_r and timeout_r, and an abort start wins over a busy timeout in the same cycle
  always_ff @(posedge i_clk)
    if (i_srst)
    begin
      pwr_ok_r <= 1'b0;
      init_done_r <= 1'b0;
      refused_r <= 1'b0;
      timeout_r <= 1'b0;
      read_setup_r <= 1'b0;
      invalid_r <= 1'b0;
      prot_r <= nps_pkg::nps_lock_t'(`NPS_LOCK_STAT_RESET);
      dstat_r <= 8'h00;
    end
    else if (i_ce)
    begin
      pwr_ok_r <= pwr_ok_r || (st_r == nps_pkg::NPS_S_PWR && tmr_zero);
      refused_r <= (wr_cmd && !start) || (refused_r && !start);
      timeout_r <= (st_busy && !start && !rb_s_r && tmr_zero) || (timeout_r && !start);
      // aborted cells are flagged invalid until next raw command
      invalid_r <= (start && op_in == nps_pkg::NPS_OP_ABORT) ||
                   (invalid_r && !(start && op_in == nps_pkg::NPS_OP_RAW));
      if (op_end && op_r == nps_pkg::NPS_OP_INIT)
        init_done_r <= 1'b1;
      // reset leaves the device in read-setup
      if (op_end && op_r != nps_pkg::NPS_OP_STAT)
        read_setup_r <= op_r == nps_pkg::NPS_OP_INIT || op_r == nps_pkg::NPS_OP_ABORT;
      // status byte kept with its fields
      if (cyc.done && act_w == nps_pkg::NPS_A_DOUT && op_r == nps_pkg::NPS_OP_PROT)
        prot_r <= nps_pkg::nps_lock_t'(cyc.rdata);
      if (cyc.done && act_w == nps_pkg::NPS_A_DOUT && op_r == nps_pkg::NPS_OP_STAT)
        dstat_r <= cyc.rdata;
    end

  // Read data stand for one cycle per strobe cycle, zero otherwise
  always_ff @(posedge i_clk)
    if (i_srst)
      rdata_r <= 32'h00000000;
    else if (i_ce)
      rdata_r <= i_rd ? rd_mux : 32'h00000000;

  assign o_rdata = rdata_r;
  assign o_ce_n  = ce_n_r;
  assign o_wp_n  = wp_r;

  rd_data_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)
    i_rd ##1 i_ce |-> o_rdata == $past(rd_mux))
    else $error("read data not one cycle after strobe");
  wp_powerup_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !init_done_r |-> !o_wp_n)
    else $error("write-protect released before init");
  pwr_wait_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (cyc.req && op_r == nps_pkg::NPS_OP_INIT) |-> pwr_ok_r)
    else $error("reset command before power-up wait");
  first_cmd_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (cyc.req && !init_done_r) |->
      (op_r == nps_pkg::NPS_OP_INIT || op_r == nps_pkg::NPS_OP_STAT))
    else $error("command other than reset before init");
  setup_ww_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (cyc.req && setup_w) |-> o_wp_n == $past(o_wp_n, 25) && $stable(o_wp_n))
    else $error("setup command before write-protect settled");
  addr_pack_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (cyc.req && cyc.kind == nps_pkg::NPS_K_ADDR) |->
      (step_r == 3'h1 && cyc.data[5:0] == 6'h00) || step_r == 3'h2 ||
      (step_r == 3'h3 && cyc.data[7:1] == 7'h00))
    else $error("address byte packing wrong");
  abort_hold_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)
    $rose(st_hold) |-> ##WP_SET_M1 (st_hold && !o_wp_n) ##1 (!st_hold && !o_wp_n))
    else $error("write-protect abort pulse length wrong");
  busy_end_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)
    (st_busy && rb_s_r && !start) |=> st_r == nps_pkg::NPS_S_STEP)
    else $error("ready not honoured");
  init_cover_c: cover property (@(posedge i_clk) disable iff (i_srst)
    op_end && op_r == nps_pkg::NPS_OP_INIT);
  prot_cover_c: cover property (@(posedge i_clk) disable iff (i_srst)
    cyc.done && act_w == nps_pkg::NPS_A_DOUT && op_r == nps_pkg::NPS_OP_PROT);
  abort_cover_c: cover property (@(posedge i_clk) disable iff (i_srst)
    start && op_in == nps_pkg::NPS_OP_ABORT && st_busy);
endmodule

// *** nps_defs.svh ***
// Constants for the NAND protection-status and reset host controller
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH

`define NPS_CLK_PERIOD_PS 4000
`define NPS_CYC_UP(ns) (((ns) * 1000 + `NPS_CLK_PERIOD_PS - 1) / `NPS_CLK_PERIOD_PS)

`define NPS_T_STB_NS  12
`define NPS_T_RDLO_NS 32
`define NPS_T_WHR_NS  60
`define NPS_T_WB_NS   100
`define NPS_T_WW_NS   100
`define NPS_T_PWR_NS  100000
`define NPS_T_INIT_NS 2000000

`define NPS_STB_CYC  `NPS_CYC_UP(`NPS_T_STB_NS)
`define NPS_RDLO_CYC `NPS_CYC_UP(`NPS_T_RDLO_NS)
`define NPS_WHR_CYC  `NPS_CYC_UP(`NPS_T_WHR_NS)
`define NPS_WB_CYC   `NPS_CYC_UP(`NPS_T_WB_NS)
`define NPS_WW_CYC   `NPS_CYC_UP(`NPS_T_WW_NS)
`define NPS_PWR_CYC  `NPS_CYC_UP(`NPS_T_PWR_NS)
`define NPS_INIT_CYC `NPS_CYC_UP(`NPS_T_INIT_NS)

`define NPS_CMD_RESET    8'hff
`define NPS_CMD_PROT_RD  8'h7a
`define NPS_CMD_STAT_RD  8'h70
`define NPS_CMD_PROG_SU  8'h80
`define NPS_CMD_ERASE_SU 8'h60

`define NPS_REG_CTRL  8'h00
`define NPS_REG_CMD   8'h04
`define NPS_REG_BADDR 8'h08
`define NPS_REG_STAT  8'h0c
`define NPS_REG_PROT  8'h10
`define NPS_REG_DSTAT 8'h14

`define NPS_LOCK_STAT_RESET 8'h0e
`endif

// *** nps_pkg.sv ***
// Types for the NAND protection-status and reset host controller
package nps_pkg;
  typedef enum logic [2:0] {
    NPS_OP_INIT  = 3'h0,
    NPS_OP_PROT  = 3'h1,
    NPS_OP_STAT  = 3'h2,
    NPS_OP_RAW   = 3'h3,
    NPS_OP_ABORT = 3'h4
  } nps_op_t;
  typedef enum logic [1:0] {
    NPS_K_CMD  = 2'h0,
    NPS_K_ADDR = 2'h1,
    NPS_K_DOUT = 2'h2
  } nps_kind_t;
  typedef enum logic [2:0] {
    NPS_A_CMD  = 3'h0,
    NPS_A_ADDR = 3'h1,
    NPS_A_DOUT = 3'h2,
    NPS_A_WHR  = 3'h3,
    NPS_A_WB   = 3'h4,
    NPS_A_BUSY = 3'h5,
    NPS_A_HOLD = 3'h6,
    NPS_A_END  = 3'h7
  } nps_act_t;
  typedef enum logic [5:0] {
    NPS_S_IDLE = 6'h01,
    NPS_S_PWR  = 6'h02,
    NPS_S_STEP = 6'h04,
    NPS_S_WAIT = 6'h08,
    NPS_S_BUSY = 6'h10,
    NPS_S_HOLD = 6'h20
  } nps_state_t;
  typedef enum logic [3:0] {
    NPS_E_IDLE = 4'h1,
    NPS_E_SET  = 4'h2,
    NPS_E_LOW  = 4'h4,
    NPS_E_HIGH = 4'h8
  } nps_eng_t;
  typedef struct packed {
    logic [2:0] rsvd;
    logic       perm_lockdown;
    logic       perm_unprot;
    logic       vol_unprot;
    logic       vol_not_lockdown;
    logic       vol_lockdown;
  } nps_lock_t;
endpackage

// *** nps_cyc_if.sv ***
// Bus-cycle request channel between sequencer and pin engine
`timescale 1ns/1ps
interface nps_cyc_if;
  logic                req;
  nps_pkg::nps_kind_t  kind;
  logic [7:0]          data;
  logic                done;
  logic [7:0]          rdata;
  modport ctl (output req, output kind, output data, input done, input rdata);
  modport eng (input req, input kind, input data, output done, output rdata);
endinterface

// *** nps_cycle.sv ***
// Pin engine: one command, address or data-out cycle per request
`timescale 1ns/1ps
`include "nps_defs.svh"
module nps_cycle #(
  parameter int STB_CYC  = `NPS_STB_CYC,
  parameter int RDLO_CYC = `NPS_RDLO_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  nps_cyc_if.eng          cyc,
  input  wire logic [7:0] i_io,
  output logic      [7:0] o_io,
  output logic            o_io_oe,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_we_n,
  output logic            o_re_n
);
  generate
    if (STB_CYC < 1 || STB_CYC > 15 || RDLO_CYC < 1 || RDLO_CYC > 15)
    begin : g_chk
      $error("nps_cycle: strobe counts must lie in 1..15");
    end
  endgenerate

  nps_pkg::nps_eng_t st_r;
  logic [3:0]        cnt_r;
  logic [7:0]        io_m_r;
  logic [7:0]        io_s_r;

  wire       is_rd    = cyc.kind == nps_pkg::NPS_K_DOUT;
  wire       cnt_zero = cnt_r == 4'h0;
  wire [3:0] stb_m1   = 4'(STB_CYC - 1);
  wire [3:0] low_m1   = is_rd ? 4'(RDLO_CYC - 1) : stb_m1;
  wire       take     = cyc.req && !cyc.done;

  // Pins are asynchronous to us
  always_ff @(posedge i_clk)
    if (i_srst)
    begin
      io_m_r <= 8'h00;
      io_s_r <= 8'h00;
    end
    else if (i_ce)
    begin
      io_m_r <= i_io;
      io_s_r <= io_m_r;
    end

  always_ff @(posedge i_clk)
    if (i_srst)
    begin
      st_r      <= nps_pkg::NPS_E_IDLE;
      cnt_r     <= 4'h0;
      o_io      <= 8'h00;
      o_io_oe   <= 1'b0;
      o_cle     <= 1'b0;
      o_ale     <= 1'b0;
      o_we_n    <= 1'b1;
      o_re_n    <= 1'b1;
      cyc.done  <= 1'b0;
      cyc.rdata <= 8'h00;
    end
    else if (i_ce)
    begin
      cyc.done <= 1'b0;
      cnt_r    <= cnt_zero ? cnt_r : cnt_r - 4'h1;
      unique case (st_r)
        nps_pkg::NPS_E_IDLE:
          if (take)
          begin
            st_r <= nps_pkg::NPS_E_SET;
            cnt_r <= stb_m1;
            o_cle <= cyc.kind == nps_pkg::NPS_K_CMD;
            o_ale <= cyc.kind == nps_pkg::NPS_K_ADDR;
            o_io_oe <= !is_rd;
            o_io <= cyc.data;
          end
        nps_pkg::NPS_E_SET:
          if (cnt_zero)
          begin
            st_r <= nps_pkg::NPS_E_LOW;
            cnt_r <= low_m1;
            o_re_n <= !is_rd;
            o_we_n <= is_rd;
          end
        nps_pkg::NPS_E_LOW:
          if (cnt_zero)
          begin
            st_r <= nps_pkg::NPS_E_HIGH;
            cnt_r <= stb_m1;
            o_re_n <= 1'b1;
            o_we_n <= 1'b1;
            if (is_rd)
              cyc.rdata <= io_s_r;
          end
        nps_pkg::NPS_E_HIGH:
          if (cnt_zero)
          begin
            st_r <= nps_pkg::NPS_E_IDLE;
            cyc.done <= 1'b1;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_io_oe <= 1'b0;
          end
      endcase
    end

  // never drive while the device may
  read_release_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !o_re_n |-> !o_io_oe)
    else $error("io driven during read strobe");
  done_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst || !i_ce)
    cyc.done |=> !cyc.done)
    else $error("done longer than one cycle");
endmodule

// *** nps_nand_m.sv ***
// Behavioural NAND device model
`timescale 1ns/1ps
module nps_nand_m #(
  parameter int INIT_NS = 400,
  parameter int RST_NS  = 200,
  parameter int PROG_NS = 4000
) (
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic       i_wp_n,
  input  wire logic [7:0] i_io,
  output logic      [7:0] o_io,
  output logic            o_rb_oe
);
  logic [7:0]  cmd_r  = 8'h00;
  logic [7:0]  last_r = 8'h00;
  logic [10:0] blk_r  = 11'h000;
  int          ac_r   = 0;
  int          gen_r  = 0;
  logic        busy_r = 1'b0;
  logic        pwr_r  = 1'b1;
  logic        prog_r = 1'b0;
  // lock-down frozen, lock per block from ba[1:0]
  wire [7:0] lock_st = {3'h0, 1'b0, ~blk_r[1], ~blk_r[0], 2'b01};
  wire [7:0] sts = {i_wp_n, ~busy_r, 6'h00};
  wire [7:0] dout = (cmd_r == 8'h70) ? sts : lock_st;
  // drive only while read strobe low; idle shows the inverse
  assign o_io = (!i_ce_n && !i_re_n) ? dout : ~last_r;
  // open drain, valid from the start, low only while busy
  assign o_rb_oe = busy_r;
  always @(posedge i_re_n) last_r = dout;
  // Newer busy period cancels the end of an older one
  task automatic go_busy(input int ns);
    int g;
    gen_r++;
    g = gen_r;
    busy_r = 1'b1;
    #(ns);
    if (gen_r == g)
    begin
      busy_r = 1'b0;
      prog_r = 1'b0;
      pwr_r = 1'b0;
    end
  endtask
  // write-protect low in program busy acts as reset
  always @(negedge i_wp_n)
  begin
    #96;
    if (prog_r && !i_wp_n)
      go_busy(RST_NS);
  end
  always @(posedge i_we_n)
  begin
    // power-up reset busy takes only status read
    if (!i_ce_n && i_cle && !(pwr_r && busy_r && i_io != 8'h70))
    begin
      cmd_r = i_io;
      ac_r = 0;
      // reset busy, then ready in read setup
      if (i_io == 8'hff)
        fork go_busy(pwr_r ? INIT_NS : RST_NS); join_none
      // setup runs only with write-protect high
      if ((i_io == 8'h80 || i_io == 8'h60) && i_wp_n)
      begin
        prog_r = 1'b1;
        fork go_busy(PROG_NS); join_none
      end
    end
    if (!i_ce_n && i_ale)
    begin
      if (ac_r == 0) blk_r[1:0] = i_io[7:6];
      if (ac_r == 1) blk_r[9:2] = i_io;
      if (ac_r == 2) blk_r[10] = i_io[0];
      ac_r++;
    end
  end
endmodule

// *** nps_host_tb.sv ***
// Self-checking bench for the NAND protection host controller
`timescale 1ns/1ps
module nps_host_tb;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_ce = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        chk = 1'b0;
  logic        chk_d = 1'b0;
  logic [31:0] o_rdata, rv, e, m, s;
  logic [7:0]  o_io, m_io, a;
  logic        o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_io_oe, rb_oe;
  logic [31:0] eq[$], mq[$];
  logic [7:0]  aq[$];
  int          err_total = 0;
  int          cmp_count = 0;
  int          i, k;
  always #2 i_clk = ~i_clk;
  nps_host #(.PWR_WAIT_CYC(20), .INIT_WAIT_CYC(500)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_cle(o_cle),
    .o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n),
    .i_io(o_io_oe ? o_io : m_io), .o_io(o_io), .o_io_oe(o_io_oe), .i_rb_n(~rb_oe));
  nps_nand_m nand_m (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_io(o_io), .o_io(m_io), .o_rb_oe(rb_oe));
  always @(posedge i_clk)
  begin
    chk_d <= i_rd & chk;
    if (chk_d)
    begin
      e = eq.pop_front();
      m = mq.pop_front();
      a = aq.pop_front();
      cmp_count++;
      if ((o_rdata & m) !== e)
      begin
        err_total++;
        $display("Error reg %h exp %h got %h", a, e, o_rdata & m);
      end
    end
  end
  task automatic tally_and_finish;
    repeat (2) @(posedge i_clk);
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic c);
    i_addr <= ad;
    i_rd <= 1'b1;
    chk <= c;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic ck(input logic [7:0] ad, input logic [31:0] mk, input logic [31:0] ex);
    aq.push_back(ad);
    mq.push_back(mk);
    eq.push_back(ex);
    rd(ad, 1'b1);
  endtask
  // Bounded wait for the operation to end (chip enable released, status bit 0 low)
  task automatic op(input logic [31:0] w);
    wr(8'h04, w);
    for (k = 0; k < 3000; k++)
    begin
      rd(8'h0c, 1'b0);
      if (rv[0] === 1'b0)
        break;
    end
    if (k == 3000)
    begin
      err_total++;
      $display("Error busy exp 0 got 1");
      tally_and_finish;
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    ck(8'h10, 32'hffffffff, 32'h0e);
    ck(8'h1c, 32'hffffffff, 32'h0);
    op(32'h1);
    ck(8'h0c, 32'h0c, 32'h08);
    $display("Defaults and refusal done");
    op(32'h0);
    ck(8'h0c, 32'h3d, 32'h24);
    $display("Init done");
    i_ce <= 1'b0;
    wr(8'h08, 32'h155);
    i_ce <= 1'b1;
    ck(8'h08, 32'h7ff, 32'h0);
    s = 32'h38e7;
    for (i = 0; i < 6; i++)
    begin
      s = (i == 5) ? 32'h7ff : lfsr(s);
      wr(8'h08, s & 32'h7ff);
      ck(8'h08, 32'h7ff, s & 32'h7ff);
      op(32'h1);
      ck(8'h10, 32'hff, {28'h0, ~s[1], ~s[0], 2'b01});
      ck(8'h0c, 32'h80, {24'h0, s[0] | s[1], 7'h0});
    end
    $display("Protection reads done");
    op(32'h2);
    ck(8'h14, 32'hff, 32'h40);
    op(32'h8003);
    ck(8'h0c, 32'h40, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h8003);
    repeat (80) @(posedge i_clk);
    op(32'h4);
    ck(8'h0c, 32'h60, 32'h60);
    op(32'h2);
    ck(8'h14, 32'hff, 32'hc0);
    op(32'h8003);
    ck(8'h0c, 32'h10, 32'h10);
    op(32'h5);
    ck(8'h0c, 32'h08, 32'h08);
    $display("Write protect and abort done");
    tally_and_finish;
  end
endmodule
